/* logic/qflag_ctrl.sv */
// Controller end: drives strobe, addresses and loops the token
`timescale 1ns/1ps
`default_nettype none
module qflag_ctrl (
   input  wire logic                               ref_clk,
   input  wire logic                               rst,
   qflag_if.ctrl                                   pins,
   input  wire logic                               polled_mode,
   input  wire logic                               read_req,
   input  wire logic [qflag_pkg::QADDR_BITS-1:0]   read_addr,
   input  wire logic                               write_sel_req,
   input  wire logic [qflag_pkg::QADDR_BITS-1:0]   write_addr,
   output logic [qflag_pkg::WORD_BITS-1:0]         status_word,
   output logic                                    status_first,
   output logic                                    write_allowed
);
   import qflag_pkg::*;

   logic                     strobe_q,  strobe_d;
   logic [QADDR_BITS-1:0]    raddr_q,   raddr_d;
   logic                     write_address_enable_q,   write_address_enable_d;
   logic [QADDR_BITS-1:0]    waddr_q,   waddr_d;
   logic [1:0]               wcnt_q,    wcnt_d;
   logic [WORD_BITS-1:0]     word_q,    word_d;
   logic                     first_q,   first_d;
   logic                     allow_q,   allow_d;

   // Request drive and flag capture
   always_comb begin
      strobe_d = 1'b0;
      raddr_d  = raddr_q;
      write_address_enable_d  = write_sel_req;
      waddr_d  = write_sel_req ? write_addr : waddr_q;
      wcnt_d   = wcnt_q;
      word_d   = pins.almost_empty_status_bus;
      first_d  = pins.empty_bus_sync;
      allow_d  = 1'b0;
      if (!polled_mode && read_req && !pins.serial_enable_out) begin
         strobe_d = 1'b1;
         raddr_d  = read_addr;
      end
      if (write_sel_req) begin
         wcnt_d = 2'h0;
      end else if (wcnt_q != 2'(FULL_VALID_CYCLES)) begin
         wcnt_d = wcnt_q + 2'h1;
      end
      // Writes allowed only once the flag is valid and high
      allow_d = !write_sel_req && wcnt_q == 2'(FULL_VALID_CYCLES) && pins.full_flag;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strobe_q <= 1'b0;
         raddr_q  <= '0;
         write_address_enable_q  <= 1'b0;
         waddr_q  <= '0;
         wcnt_q   <= 2'h0;
         word_q   <= STATUS_RESET;
         first_q  <= 1'b0;
         allow_q  <= 1'b0;
      end else begin
         strobe_q <= strobe_d;
         raddr_q  <= raddr_d;
         write_address_enable_q  <= write_address_enable_d;
         waddr_q  <= waddr_d;
         wcnt_q   <= wcnt_d;
         word_q   <= word_d;
         first_q  <= first_d;
         allow_q  <= allow_d;
      end
   end

   // Single device: token looped in polled mode, tied low in direct
   assign pins.chain_token_in       = polled_mode & pins.chain_token_out;
   assign pins.flag_bus_mode_select = polled_mode;
   assign pins.empty_bus_strobe     = strobe_q;
   assign pins.read_queue_address   = raddr_q;
   assign pins.write_address_enable = write_address_enable_q;
   assign pins.write_queue_address  = waddr_q;
   assign status_word   = word_q;
   assign status_first  = first_q;
   assign write_allowed = allow_q;
endmodule : qflag_ctrl
`default_nettype wire

/* logic/qflag_device.sv */
// Device end: almost-empty status bus, token chain and shared full flag
// What this block does
// - Direct mode: strobe loads addressed status word
// - Polled mode: controller holds strobe low
// - No strobe before programming done
// - Polled: one word per clock, wraps
// - Sync high only with word one
// - Chain token input from previous device
// - Single device: token tied/looped
// - Direct chain: first token input low
// - Token out pulses with fourth word
// - Token in starts first word next
// - Last token out loops to first
// - Write queue selected by address enable
// - Full flag valid third cycle later
// - Write only after valid flag high
// - Only selected device drives full flag
// - Drive full flag next cycle after select
// - Mode input sampled at reset release
`timescale 1ns/1ps
`default_nettype none
module qflag_device #(
   parameter int DEVICE_QUEUES = qflag_pkg::QUEUES,
   parameter logic [0:0] DEVICE_BASE = 1'b0,  // Upper write address bit owned by this device
   parameter logic [0:0] CHAIN_HEAD  = 1'b1   // This device seeds the first polled pass
) (
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst,
   qflag_if.device                                   pins,
   input  wire logic [qflag_pkg::QUEUES-1:0]         queue_almost_empty_n,
   input  wire logic [qflag_pkg::QUEUES-1:0]         queue_full_n,
   input  wire logic                                 programming_done
);
   import qflag_pkg::*;

   flag_mode_t                 mode_q,        mode_d;
   logic                       mode_taken_q,  mode_taken_d;
   logic [WORD_BITS-1:0]       status_q,      status_d;
   logic [WORD_SEL_BITS-1:0]   word_q,        word_d;
   logic                       polling_q,     polling_d;
   logic                       sync_q,        sync_d;
   logic                       token_q,       token_d;
   logic                       serial_enable_out_q,        serial_enable_out_d;
   logic                       selected_q,    selected_d;
   logic [QADDR_BITS-1:0]      wqueue_q,      wqueue_d;
   logic [1:0]                 full_cnt_q,    full_cnt_d;
   logic                       full_q,        full_d;
   logic                       oe_n_q,        oe_n_d;
   logic                       seeded_q,      seeded_d;
   logic                       launch;

   // Picks one eight-queue group of almost-empty flags
   // Queues beyond the device size read as not almost empty, so a smaller part never reports ghosts
   function automatic logic [WORD_BITS-1:0] status_word(input logic [WORD_SEL_BITS-1:0] sel);
      logic [WORD_BITS-1:0] grp;
      grp = queue_almost_empty_n[sel*WORD_BITS +: WORD_BITS];
      for (int b = 0; b < WORD_BITS; b++) begin
         if (int'(sel) * WORD_BITS + b >= DEVICE_QUEUES) begin
            grp[b] = 1'b1;
         end
      end
      return grp;
   endfunction : status_word

   // A pass starts on a token from the chain, or once from the chain head after programming
   assign launch = pins.chain_token_in || (CHAIN_HEAD && !seeded_q && !serial_enable_out_q);

   // Chain head seeding is remembered so a returning token is the only later trigger
   always_comb begin
      seeded_d = seeded_q;
      if (mode_taken_q && mode_q == MODE_POLLED && launch) begin
         seeded_d = 1'b1;
      end
   end

   // Seeding register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         seeded_q <= 1'b0;
      end else begin
         seeded_q <= seeded_d;
      end
   end

   // Read side: mode capture, direct strobe and polled rotation
   always_comb begin
      mode_d       = mode_q;
      mode_taken_d = 1'b1;
      status_d     = status_q;
      word_d       = word_q;
      polling_d    = polling_q;
      sync_d       = 1'b0;
      token_d      = 1'b0;
      serial_enable_out_d       = ~programming_done;
      if (!mode_taken_q) begin
         // Mode is caught once, on the first edge after reset release
         // The mode input must stay put afterwards; a later change is ignored
         mode_d = pins.flag_bus_mode_select ? MODE_POLLED : MODE_DIRECT;
      end else if (mode_q == MODE_DIRECT) begin
         // Strobe is trusted only once programming is done
         if (pins.empty_bus_strobe && !serial_enable_out_q) begin
            status_d = status_word(pins.read_queue_address[WORD_SEL_BITS-1:0]);
         end
      end else begin
         // Token is taken while idle or as word four leaves; mid-rotation it is dropped
         if (launch && (!polling_q || word_q == LAST_WORD)) begin
            polling_d = 1'b1;
            word_d    = FIRST_WORD;
            status_d  = status_word(FIRST_WORD);
            sync_d    = 1'b1;
         end else if (polling_q) begin
            if (word_q == LAST_WORD) begin
               // Bus handed to the next device; hold last word until token returns
               polling_d = 1'b0;
            end else begin
               word_d   = word_q + 2'h1;
               status_d = status_word(word_q + 2'h1);
               token_d  = (word_q + 2'h1) == LAST_WORD;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q       <= MODE_DIRECT;
         mode_taken_q <= 1'b0;
         status_q     <= STATUS_RESET;
         word_q       <= FIRST_WORD;
         polling_q    <= 1'b0;
         sync_q       <= 1'b0;
         token_q      <= 1'b0;
         serial_enable_out_q       <= 1'b1;
      end else begin
         mode_q       <= mode_d;
         mode_taken_q <= mode_taken_d;
         status_q     <= status_d;
         word_q       <= word_d;
         polling_q    <= polling_d;
         sync_q       <= sync_d;
         token_q      <= token_d;
         serial_enable_out_q       <= serial_enable_out_d;
      end
   end

   // Write side ownership: the select edge decides who drives the shared line
   always_comb begin
      selected_d = selected_q;
      wqueue_d   = wqueue_q;
      oe_n_d     = oe_n_q;
      if (pins.write_address_enable) begin
         // Top address bit picks one of up to two devices on the line
         selected_d = pins.write_queue_address[QADDR_BITS-1] == DEVICE_BASE;
         wqueue_d   = pins.write_queue_address;
         // Released on the edge after a foreign select, the same edge the new owner starts driving, so two drivers never fight
         oe_n_d     = ~selected_d;
      end
   end

   // Ownership registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         selected_q <= 1'b0;
         wqueue_q   <= '0;
         oe_n_q     <= 1'b1;
      end else begin
         selected_q <= selected_d;
         wqueue_q   <= wqueue_d;
         oe_n_q     <= oe_n_d;
      end
   end

   // Write side latency: the flag stays low until the new queue status has settled
   always_comb begin
      full_cnt_d = full_cnt_q;
      full_d     = full_q;
      if (pins.write_address_enable) begin
         full_cnt_d = FULL_CNT_RESET;
         full_d     = 1'b0;                              // Stale until the new queue is valid
      end else if (selected_q) begin
         if (full_cnt_q != 2'(FULL_VALID_CYCLES - 1)) begin
            full_cnt_d = full_cnt_q + 2'h1;
         end
         if (full_cnt_q >= 2'(FULL_VALID_CYCLES - 2)) begin
            full_d = queue_full_n[wqueue_q];
         end
      end
   end

   // Latency registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         full_cnt_q <= FULL_CNT_RESET;
         full_q     <= 1'b0;
      end else begin
         full_cnt_q <= full_cnt_d;
         full_q     <= full_d;
      end
   end

   // Pins come straight from flops, so no glitch reaches the shared lines
   assign pins.almost_empty_status_bus = status_q;
   assign pins.empty_bus_sync          = sync_q;
   assign pins.chain_token_out         = token_q;
   assign pins.serial_enable_out       = serial_enable_out_q;
   assign pins.full_flag_o             = full_q;
   assign pins.full_flag_oe_n          = oe_n_q;
endmodule : qflag_device
`default_nettype wire

/* logic/qflag_if.sv */
// Pin-level carrier between the flag device and the controller
`timescale 1ns/1ps
`default_nettype none
interface qflag_if;
   import qflag_pkg::*;
   logic [WORD_BITS-1:0]     almost_empty_status_bus;
   logic                     empty_bus_strobe;
   logic                     empty_bus_sync;
   logic [QADDR_BITS-1:0]    read_queue_address;
   logic                     chain_token_in;
   logic                     chain_token_out;
   logic [QADDR_BITS-1:0]    write_queue_address;
   logic                     write_address_enable;
   logic                     full_flag_o;
   logic                     full_flag_oe_n;
   logic                     full_flag;        // Resolved shared line, high when floating
   logic                     serial_enable_out;
   logic                     flag_bus_mode_select;

   assign full_flag = full_flag_oe_n ? 1'b1 : full_flag_o;

   modport device (
      output almost_empty_status_bus,
      input  empty_bus_strobe,
      output empty_bus_sync,
      input  read_queue_address,
      input  chain_token_in,
      output chain_token_out,
      input  write_queue_address,
      input  write_address_enable,
      output full_flag_o,
      output full_flag_oe_n,
      output serial_enable_out,
      input  flag_bus_mode_select
   );
   modport ctrl (
      input  almost_empty_status_bus,
      output empty_bus_strobe,
      input  empty_bus_sync,
      output read_queue_address,
      output chain_token_in,
      input  chain_token_out,
      output write_queue_address,
      output write_address_enable,
      input  full_flag,
      input  serial_enable_out,
      output flag_bus_mode_select
   );
endinterface : qflag_if
`default_nettype wire

/* logic/qflag_pkg.sv */
// Shared constants and types for the queue flag status logic
package qflag_pkg;
   localparam int QUEUES          = 32;                // Four words of eight queues
   localparam int WORD_BITS       = 8;
   localparam int WORD_COUNT      = 4;
   localparam int WORD_SEL_BITS   = 2;
   localparam int QADDR_BITS      = 5;
   localparam logic [1:0] FIRST_WORD = 2'h0;
   localparam logic [1:0] LAST_WORD  = 2'h3;
   localparam int FULL_VALID_CYCLES = 3;               // Full flag valid on 3rd cycle
   localparam logic [1:0] FULL_CNT_RESET = 2'h0;
   localparam logic [7:0] STATUS_RESET = 8'hFF;        // Almost-empty flags are active low
   typedef enum logic [1:0] {
      MODE_DIRECT,
      MODE_POLLED
   } flag_mode_t;
endpackage : qflag_pkg

/* test/qflag_assertions.sv */
// Pin-level timing checks between the flag device and its controller
`timescale 1ns/1ps
`default_nettype none
module qflag_assertions
   import qflag_pkg::*;
#(
   parameter logic [0:0] DEVICE_BASE = 1'b0
) (
   input wire logic                  ref_clk,
   input wire logic                  rst,
   input wire logic [WORD_BITS-1:0]  almost_empty_status_bus,
   input wire logic                  empty_bus_strobe,
   input wire logic                  empty_bus_sync,
   input wire logic                  chain_token_in,
   input wire logic                  chain_token_out,
   input wire logic [QADDR_BITS-1:0] write_queue_address,
   input wire logic                  write_address_enable,
   input wire logic                  full_flag_oe_n,
   input wire logic                  full_flag,
   input wire logic                  serial_enable_out,
   input wire logic                  flag_bus_mode_select
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Words two to four follow word one; the token leaves with the last one
   sequence rest_of_rotation;
      (!empty_bus_sync && !chain_token_out) [*2] ##1 (!empty_bus_sync && chain_token_out);
   endsequence
   // Flag is forced low while the new queue status is not yet valid
   sequence driven_low_two;
      (!full_flag_oe_n && !full_flag) [*2];
   endsequence
   a_direct_bus_hold: assert property (!flag_bus_mode_select && !empty_bus_strobe |=>
      $stable(almost_empty_status_bus)) else $error("status bus moved without a strobe");
   a_polled_strobe_low: assert property (flag_bus_mode_select |-> !empty_bus_strobe)
      else $error("strobe raised in polled mode");
   a_strobe_after_prog: assert property (empty_bus_strobe |-> !serial_enable_out)
      else $error("strobe raised before programming finished");
   a_word_rotation: assert property (empty_bus_sync |=> rest_of_rotation)
      else $error("polled word order broken");
   a_token_with_last: assert property (chain_token_out |-> $past(empty_bus_sync, 3))
      else $error("token pulse not aligned with fourth word");
   a_direct_no_sync: assert property (!flag_bus_mode_select |-> !empty_bus_sync && !chain_token_out)
      else $error("sync or token active in direct mode");
   a_token_starts_word: assert property (flag_bus_mode_select && chain_token_in
      |=> empty_bus_sync) else $error("token did not start word one");
   a_select_drives: assert property (write_address_enable && write_queue_address[4] == DEVICE_BASE
      |=> driven_low_two) else $error("full flag not driven low after select");
   a_other_floats: assert property (write_address_enable && write_queue_address[4] != DEVICE_BASE
      |=> full_flag_oe_n) else $error("full flag driven for a foreign queue");
   a_drive_holds: assert property (!write_address_enable |=> $stable(full_flag_oe_n))
      else $error("full flag drive changed without a select");
endmodule : qflag_assertions
`default_nettype wire

/* test/test_queue_flag_status_bus.sv */
// Self-checking bench: controller and device joined pin to pin
`timescale 1ns/1ps
`default_nettype none
module test_queue_flag_status_bus;
   import qflag_pkg::*;
   logic                  ref_clk;
   logic                  rst;
   logic [QUEUES-1:0]     qae_n;
   logic [QUEUES-1:0]     qfull_n;
   logic                  prog_done;
   logic                  polled_mode;
   logic                  read_req;
   logic [QADDR_BITS-1:0] read_addr;
   logic                  write_sel_req;
   logic [QADDR_BITS-1:0] write_addr;
   logic [WORD_BITS-1:0]  status_word;
   logic                  status_first;
   logic                  write_allowed;
   logic [7:0]            expq[$];
   int                    failures;
   int                    checks_done;
   qflag_if pins ();
   qflag_device #(.DEVICE_BASE(1'b0)) qflag_device_i (.ref_clk(ref_clk), .rst(rst), .pins(pins),
      .queue_almost_empty_n(qae_n), .queue_full_n(qfull_n), .programming_done(prog_done));
   qflag_ctrl qflag_ctrl_i (.ref_clk(ref_clk), .rst(rst), .pins(pins), .polled_mode(polled_mode),
      .read_req(read_req), .read_addr(read_addr), .write_sel_req(write_sel_req), .write_addr(write_addr),
      .status_word(status_word), .status_first(status_first), .write_allowed(write_allowed));
   qflag_assertions #(.DEVICE_BASE(1'b0)) qflag_assertions_i (.ref_clk(ref_clk), .rst(rst),
      .almost_empty_status_bus(pins.almost_empty_status_bus), .empty_bus_strobe(pins.empty_bus_strobe),
      .empty_bus_sync(pins.empty_bus_sync), .chain_token_in(pins.chain_token_in),
      .chain_token_out(pins.chain_token_out), .write_queue_address(pins.write_queue_address),
      .write_address_enable(pins.write_address_enable), .full_flag_oe_n(pins.full_flag_oe_n),
      .full_flag(pins.full_flag), .serial_enable_out(pins.serial_enable_out),
      .flag_bus_mode_select(pins.flag_bus_mode_select));
   // Free-running reference clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   // One edge, then let the registered outputs settle
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic do_reset();
      @(negedge ref_clk);
      rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
   endtask : do_reset
   // Direct read: request is dropped once the strobe shows, so only one word is taken
   task automatic rd(input logic [QADDR_BITS-1:0] a);
      int n;
      n = 0;
      @(negedge ref_clk);
      read_req = 1'b1;
      read_addr = a;
      while (pins.empty_bus_strobe !== 1'b1 && n < 16) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 16) failures++;
      read_req = 1'b0;
      expq.push_back(qae_n[8*a[1:0] +: 8]);
      step();
      check(pins.almost_empty_status_bus, expq[0]);
      step();
      check(status_word, expq.pop_front());
   endtask : rd
   // Write select: flag forced low two cycles, valid on the third
   task automatic wr(input logic [QADDR_BITS-1:0] a);
      int n;
      logic sel;
      n = 0;
      sel = (a[4] == 1'b0);
      @(negedge ref_clk);
      write_sel_req = 1'b1;
      write_addr = a;
      while (pins.write_address_enable !== 1'b1 && n < 16) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 16) failures++;
      write_sel_req = 1'b0;
      step();
      for (int k = 1; k < 3; k++) begin
         check(pins.full_flag_oe_n, !sel);
         check(pins.full_flag, !sel);
         step();
      end
      check(pins.full_flag, sel ? qfull_n[a] : 1'b1);
      step();
      check(write_allowed, sel ? qfull_n[a] : 1'b1);
   endtask : wr
   // Main sequence
   initial begin
      int n;
      failures = 0;
      checks_done = 0;
      rst = 1'b1;
      prog_done = 1'b0;
      polled_mode = 1'b0;
      read_req = 1'b0;
      read_addr = '0;
      write_sel_req = 1'b0;
      write_addr = '0;
      void'($urandom(62291));
      qae_n = $urandom;
      qfull_n = $urandom;
      do_reset();
      read_req = 1'b1;
      read_addr = 5'h02;
      repeat (4) step();
      check(pins.almost_empty_status_bus, STATUS_RESET);
      @(negedge ref_clk);
      read_req = 1'b0;
      prog_done = 1'b1;
      n = 0;
      while (pins.serial_enable_out !== 1'b0 && n < 32) begin
         step();
         n++;
      end
      for (int a = 0; a < 4; a++) rd(QADDR_BITS'(a));
      repeat (4) rd(QADDR_BITS'($urandom));
      wr(5'h00);
      wr(5'h1F);
      repeat (6) wr(QADDR_BITS'($urandom));
      @(negedge ref_clk);
      polled_mode = 1'b1;
      do_reset();
      n = 0;
      while (pins.empty_bus_sync !== 1'b1 && n < 40) begin
         step();
         n++;
      end
      repeat (3) begin
         for (int k = 0; k < 4; k++) expq.push_back(qae_n[8*k +: 8]);
         for (int k = 0; k < 4; k++) begin
            check(pins.almost_empty_status_bus, expq.pop_front());
            check(pins.empty_bus_sync, k == 0);
            check(pins.chain_token_out, k == 3);
            check(status_first, k == 1);
            step();
         end
      end
      conclude();
   end
   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #(5000 * 100);
      failures++;
      conclude();
   end
endmodule : test_queue_flag_status_bus
`default_nettype wire
